// *** rtl/fbx_map.vh ***
// fbx_map.vh: opcodes, field positions, reset values and counts
// assumes: included by the executor and its divider, no process here
`ifndef FBX_MAP_VH
`define FBX_MAP_VH
`define FBX_XLEN 32
`define FBX_MAJ_HI 31
`define FBX_MAJ_LO 26
`define FBX_RD_HI 25
`define FBX_RD_LO 21
`define FBX_RA_HI 20
`define FBX_RA_LO 16
`define FBX_RB_HI 15
`define FBX_RB_LO 11
`define FBX_SEC_HI 9
`define FBX_SEC_LO 6
`define FBX_DSEC_HI 9
`define FBX_DSEC_LO 8
`define FBX_LOW_HI 3
`define FBX_LOW_LO 0
`define FBX_IMM_HI 25
`define FBX_OP_BNF 6'h03
`define FBX_OP_ALU 6'h38
`define FBX_OP_CUST1 6'h1c
`define FBX_OP_CUST2 6'h1d
`define FBX_OP_CUST3 6'h1e
`define FBX_OP_CUST4 6'h1f
`define FBX_OP_CUST5 6'h3c
`define FBX_OP_CUST6 6'h3d
`define FBX_OP_CUST7 6'h3e
`define FBX_OP_CUST8 6'h3f
`define FBX_CSYNC_WORD 32'h23000000
`define FBX_LOW_CMOV 4'he
`define FBX_SEC_CMOV 2'h0
`define FBX_SEC_DIV 2'h3
`define FBX_LOW_DIV 4'h9
`define FBX_LOW_DIVU 4'ha
`define FBX_SEC_EXTBS 4'h1
`define FBX_SEC_EXTBZ 4'h3
`define FBX_LOW_EXTB 4'hc
`define FBX_BYTE_MSB 7
`define FBX_DIV_STEPS 6'h20
`define FBX_RST_WORD 32'h00000000
`endif

// *** rtl/fbx_divider.v ***
// fbx_divider.v: iterative 32-bit divider, one quotient bit per cycle
// assumes: operands stable while start is pulsed, same clock as executor
`timescale 1ns/100ps
`include "fbx_map.vh"
module fbx_divider (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// request
	input wire start,
	input wire is_signed,
	input wire [31:0] dividend,
	input wire [31:0] divisor,
	// result
	output reg done,
	output reg [31:0] quotient,
	output reg div_zero,
	output reg div_ovf
);
	reg [31:0] rem_r;
	reg [31:0] quo_r;
	reg [31:0] den_r;
	reg neg_r;
	reg busy_r;
	reg [5:0] cnt_r;
	wire a_neg = is_signed & dividend[31];
	wire b_neg = is_signed & divisor[31];
	wire [31:0] a_mag = a_neg ? (~dividend + 32'h00000001) : dividend;
	wire [31:0] b_mag = b_neg ? (~divisor + 32'h00000001) : divisor;
	wire [32:0] trial = {rem_r, quo_r[31]} - {1'b0, den_r};
	always @(posedge clk) begin
		if (!rst_n) begin
			rem_r <= `FBX_RST_WORD;
			quo_r <= `FBX_RST_WORD;
			den_r <= `FBX_RST_WORD;
			neg_r <= 1'b0;
			busy_r <= 1'b0;
			cnt_r <= 6'h00;
			done <= 1'b0;
			quotient <= `FBX_RST_WORD;
			div_zero <= 1'b0;
			div_ovf <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				rem_r <= 32'h00000000;
				quo_r <= a_mag;
				den_r <= b_mag;
				neg_r <= a_neg ^ b_neg;
				// zero divisor and most-negative over -1 cannot fit
				div_zero <= (divisor == 32'h00000000);
				div_ovf <= is_signed & (dividend == 32'h80000000) & (divisor == 32'hffffffff);
				busy_r <= 1'b1;
				cnt_r <= `FBX_DIV_STEPS;
			end else if (busy_r) begin
				if (!trial[32]) begin
					rem_r <= trial[31:0];
				end else begin
					rem_r <= {rem_r[30:0], quo_r[31]};
				end
				quo_r <= {quo_r[30:0], ~trial[32]};
				cnt_r <= cnt_r - 6'h01;
				if (cnt_r == 6'h01) begin
					busy_r <= 1'b0;
					done <= 1'b1;
					quotient <= neg_r ? (~{quo_r[30:0], ~trial[32]} + 32'h00000001)
						: {quo_r[30:0], ~trial[32]};
				end
			end
		end
	end
endmodule

// *** rtl/fbx_exec.v ***
// fbx_exec.v: decode and execute of branch-on-clear, cmov, context sync,
// divide, byte extend, and custom-slot hand-off
// assumes: fetch holds instr_valid/instr until instr_ready; gpr values arrive with the word
`timescale 1ns/100ps
`include "fbx_map.vh"
// Operation
// [RULE1] target is sign-extended imm26 times four plus pc
// [RULE2] flag clear: branch after one delay slot
// [RULE3] cmov picks first source if flag set
// [RULE4] sync word: drain operations, then flush pipelines
// [RULE5] resume fetch with empty pipe, fresh context
// [RULE6] custom major opcodes decoded as reserved slots
// [RULE7] custom slots exported to implementation logic
// [RULE8] signed divide writes signed quotient
// [RULE9] unsigned divide writes unsigned quotient
// [RULE10] zero divisor sets carry flag
// [RULE11] divide sets overflow, may raise range; others never
// [RULE12] sign-extend byte from bit seven
// [RULE13] zero-extend byte clears upper bits
// [RULE14] basic ops mandatory, divide optional by parameter
module fbx_exec #(
	parameter DIV_PRESENT = 1
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// instruction from fetch
	input wire instr_valid,
	input wire [31:0] instr,
	input wire [31:0] instr_pc,
	output wire instr_ready,
	// register operands
	input wire [31:0] src_a,
	input wire [31:0] src_b,
	// supervision register flags
	input wire compare_flag,
	output reg carry_flag_we,
	output reg carry_flag,
	output reg overflow_flag_we,
	output reg overflow_flag,
	output reg range_exc,
	output reg illegal_insn,
	// register write-back
	output reg rd_we,
	output reg [4:0] rd_addr,
	output reg [31:0] rd_data,
	// program flow
	output reg redirect,
	output reg [31:0] effective_target,
	output reg flush,
	// context synchronisation handshake with core
	input wire ops_idle,
	// custom slot hand-off
	output reg custom_valid,
	output reg [7:0] custom_slot,
	output reg [31:0] custom_word,
	input wire custom_done
);
	localparam ST_IDLE = 4'b0001;
	localparam ST_DIV = 4'b0010;
	localparam ST_SYNC = 4'b0100;
	localparam ST_CUST = 4'b1000;

	// slot index 0..7 for a custom major opcode, 4'h8 when not custom
	function [3:0] cust_index;
		input [5:0] maj;
		begin
			case (maj)
			`FBX_OP_CUST1: cust_index = 4'h0;
			`FBX_OP_CUST2: cust_index = 4'h1;
			`FBX_OP_CUST3: cust_index = 4'h2;
			`FBX_OP_CUST4: cust_index = 4'h3;
			`FBX_OP_CUST5: cust_index = 4'h4;
			`FBX_OP_CUST6: cust_index = 4'h5;
			`FBX_OP_CUST7: cust_index = 4'h6;
			`FBX_OP_CUST8: cust_index = 4'h7;
			default: cust_index = 4'h8;
			endcase
		end
	endfunction

	reg [3:0] state_r;
	reg branch_pend_r;
	reg [31:0] target_r;
	reg [4:0] div_rd_r;

	wire [5:0] maj = instr[`FBX_MAJ_HI:`FBX_MAJ_LO];
	wire [4:0] f_rd = instr[`FBX_RD_HI:`FBX_RD_LO];
	wire [3:0] f_low = instr[`FBX_LOW_HI:`FBX_LOW_LO];
	wire [1:0] f_dsec = instr[`FBX_DSEC_HI:`FBX_DSEC_LO];
	wire [3:0] f_sec = instr[`FBX_SEC_HI:`FBX_SEC_LO];
	wire [3:0] cidx = cust_index(maj);
	wire is_alu = (maj == `FBX_OP_ALU);
	wire is_bnf = (maj == `FBX_OP_BNF);
	wire is_sync = (instr == `FBX_CSYNC_WORD);
	wire is_cmov = is_alu & (f_dsec == `FBX_SEC_CMOV) & (f_low == `FBX_LOW_CMOV);
	wire is_div = is_alu & (f_dsec == `FBX_SEC_DIV) & (f_low == `FBX_LOW_DIV);
	wire is_divu = is_alu & (f_dsec == `FBX_SEC_DIV) & (f_low == `FBX_LOW_DIVU);
	wire is_extbs = is_alu & (f_sec == `FBX_SEC_EXTBS) & (f_low == `FBX_LOW_EXTB);
	wire is_extbz = is_alu & (f_sec == `FBX_SEC_EXTBZ) & (f_low == `FBX_LOW_EXTB);
	wire is_cust = ~cidx[3];
	wire div_ok = (DIV_PRESENT != 0);
	wire take = instr_valid & instr_ready;
	// branch offset: imm26 << 2, sign-extended to pc width
	wire [31:0] br_off = {{4{instr[`FBX_IMM_HI]}}, instr[`FBX_IMM_HI:0], 2'b00}; // [RULE1]

	wire div_done;
	wire [31:0] div_q;
	wire div_zero;
	wire div_ovf;

	// stalls fetch while a multi-cycle operation is open
	assign instr_ready = (state_r == ST_IDLE);

	fbx_divider u_div (
		.clk(clk),
		.rst_n(rst_n),
		.start(take & (is_div | is_divu) & div_ok),
		.is_signed(is_div), // [RULE8] [RULE9]
		.dividend(src_a),
		.divisor(src_b),
		.done(div_done),
		.quotient(div_q),
		.div_zero(div_zero),
		.div_ovf(div_ovf)
	);

	always @(posedge clk) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			branch_pend_r <= 1'b0;
			target_r <= `FBX_RST_WORD;
			div_rd_r <= 5'h00;
			carry_flag_we <= 1'b0;
			carry_flag <= 1'b0;
			overflow_flag_we <= 1'b0;
			overflow_flag <= 1'b0;
			range_exc <= 1'b0;
			illegal_insn <= 1'b0;
			rd_we <= 1'b0;
			rd_addr <= 5'h00;
			rd_data <= `FBX_RST_WORD;
			redirect <= 1'b0;
			effective_target <= `FBX_RST_WORD;
			flush <= 1'b0;
			custom_valid <= 1'b0;
			custom_slot <= 8'h00;
			custom_word <= `FBX_RST_WORD;
		end else begin
			rd_we <= 1'b0;
			redirect <= 1'b0;
			flush <= 1'b0;
			carry_flag_we <= 1'b0;
			overflow_flag_we <= 1'b0;
			range_exc <= 1'b0;
			illegal_insn <= 1'b0;
			case (state_r)
			ST_IDLE: begin
				if (take) begin
					// the word after a taken branch is its delay slot
					if (branch_pend_r) begin
						branch_pend_r <= 1'b0;
						redirect <= 1'b1; // [RULE2]
						effective_target <= target_r;
					end
					if (is_bnf) begin
						target_r <= br_off + instr_pc; // [RULE1]
						branch_pend_r <= ~compare_flag; // [RULE2]
					end else if (is_cmov) begin
						rd_we <= 1'b1;
						rd_addr <= f_rd;
						rd_data <= compare_flag ? src_a : src_b; // [RULE3]
					end else if (is_sync) begin
						state_r <= ST_SYNC; // [RULE4]
					end else if (is_extbs | is_extbz) begin
						rd_we <= 1'b1;
						rd_addr <= f_rd;
						rd_data <= {{24{is_extbs & src_a[`FBX_BYTE_MSB]}}, src_a[7:0]}; // [RULE12] [RULE13]
					end else if ((is_div | is_divu) & div_ok) begin
						div_rd_r <= f_rd;
						state_r <= ST_DIV;
					end else if ((is_div | is_divu) & ~div_ok) begin
						illegal_insn <= 1'b1; // [RULE14]
					end else if (is_cust) begin
						custom_valid <= 1'b1; // [RULE6]
						custom_slot <= 8'h01 << cidx[2:0]; // [RULE7]
						custom_word <= instr;
						state_r <= ST_CUST;
					end
				end
			end
			ST_DIV: begin
				if (div_done) begin
					rd_we <= 1'b1;
					rd_addr <= div_rd_r;
					rd_data <= div_q; // [RULE8] [RULE9]
					carry_flag_we <= 1'b1;
					carry_flag <= div_zero; // [RULE10]
					overflow_flag_we <= 1'b1;
					overflow_flag <= div_zero | div_ovf; // [RULE11]
					range_exc <= div_zero | div_ovf; // [RULE11]
					state_r <= ST_IDLE;
				end
			end
			ST_SYNC: begin
				// wait for the core to drain before flushing
				if (ops_idle) begin
					flush <= 1'b1; // [RULE4] [RULE5]
					branch_pend_r <= 1'b0;
					state_r <= ST_IDLE;
				end
			end
			ST_CUST: begin
				if (custom_done) begin
					custom_valid <= 1'b0;
					state_r <= ST_IDLE;
				end
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end
endmodule

// *** tb/fbx_core_model.sv ***
// fbx_core_model.sv: core side, outstanding ops and custom unit
// assumes: stall seen as instr_ready low, lag set by the bench
`timescale 1ns/100ps
module fbx_core_model (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// executor side
	input wire instr_ready,
	input wire custom_valid,
	input wire [3:0] lag,
	output wire ops_idle,
	output wire custom_done
);
	reg [4:0] cnt_r;
	always @(posedge clk) begin
		if (!rst_n || instr_ready)
			cnt_r <= 5'h00;
		else if (cnt_r != 5'h1f)
			cnt_r <= cnt_r + 5'h01;
	end
	// ops drain lag cycles into a stall, never sooner, so slow cores get tested
	assign ops_idle = cnt_r >= {1'b0, lag};
	assign custom_done = custom_valid && ops_idle;
endmodule

// *** tb/fbx_exec_sva.sv ***
// fbx_exec_sva.sv: port checks for the executor
// assumes: bound to fbx_exec, sync active-low reset
`timescale 1ns/100ps
`include "fbx_map.vh"
module fbx_exec_sva #(
	parameter DIV_PRESENT = 1
) (
	// clock, reset, fetch side
	input wire clk,
	input wire rst_n,
	input wire instr_valid,
	input wire [31:0] instr,
	input wire instr_ready,
	input wire [31:0] src_a,
	input wire [31:0] src_b,
	input wire compare_flag,
	// results
	input wire carry_flag_we,
	input wire carry_flag,
	input wire overflow_flag_we,
	input wire overflow_flag,
	input wire range_exc,
	input wire illegal_insn,
	input wire rd_we,
	input wire [31:0] rd_data,
	input wire flush,
	input wire ops_idle,
	input wire custom_valid,
	input wire [7:0] custom_slot,
	input wire [31:0] custom_word
);
	wire tk = instr_valid && instr_ready;
	wire alu = tk && instr[31:26] == `FBX_OP_ALU;
	wire mv = alu && instr[9:0] == 10'h00e;
	wire sx = alu && instr[9:0] == 10'h04c;
	wire zx = alu && instr[9:0] == 10'h0cc;
	wire dv = alu && (instr[9:0] == 10'h309 || instr[9:0] == 10'h30a) && DIV_PRESENT != 0;
	wire cs = tk && instr[30:28] == 3'h7;
	wire sy = tk && instr == `FBX_CSYNC_WORD;
	wire bn = tk && instr[31:26] == `FBX_OP_BNF;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence div_take;
		dv;
	endsequence
	sequence div_answer;
		rd_we && carry_flag_we && overflow_flag_we;
	endsequence
	cmov_pick_a: assert property (mv |=> rd_we && rd_data ==
		($past(compare_flag) ? $past(src_a) : $past(src_b))) else $error("cmov value");
	sign_byte_a: assert property (sx |=> rd_we &&
		rd_data == {{24{$past(src_a[7])}}, $past(src_a[7:0])}) else $error("extbs value");
	zero_byte_a: assert property (zx |=> rd_we &&
		rd_data == {24'h0, $past(src_a[7:0])}) else $error("extbz value");
	div_latency_a: assert property (div_take |-> ##34 div_answer)
		else $error("divide answer late");
	div_zero_a: assert property (div_take ##0 src_b == 32'h0 |-> ##34 carry_flag)
		else $error("zero divisor carry");
	range_flag_a: assert property (range_exc |-> overflow_flag_we && overflow_flag)
		else $error("range without overflow");
	quiet_ops_a: assert property ((mv || sx || zx || sy || bn) |=>
		!range_exc && !illegal_insn) else $error("exception on plain op");
	div_legal_a: assert property (dv |=> !illegal_insn && !instr_ready)
		else $error("divide refused");
	sync_stall_a: assert property (sy |=> !instr_ready) else $error("sync not stalled");
	sync_flush_a: assert property (sy |-> ##[2:40] flush) else $error("no flush");
	drain_first_a: assert property (flush |-> $past(ops_idle))
		else $error("flush before drain");
	resume_a: assert property (flush |-> ##[0:1] instr_ready) else $error("no resume");
	custom_slot_a: assert property (cs |=> custom_valid && $onehot(custom_slot) &&
		custom_word == $past(instr)) else $error("custom hand-off");
endmodule
bind fbx_exec fbx_exec_sva #(.DIV_PRESENT(DIV_PRESENT)) chk (.*);

// *** tb/tb_flag_branch_divide_extend_exec.sv ***
// tb_flag_branch_divide_extend_exec.sv: random and corner runs of fbx_exec
// assumes: core model answers stalls, 40 MHz clock
`timescale 1ns/100ps
`include "fbx_map.vh"
module tb_flag_branch_divide_extend_exec;
	reg clk, rst_n, instr_valid, compare_flag, sg;
	reg [31:0] instr, instr_pc, src_a, src_b, rnd, a, b, q, t;
	reg [3:0] lag;
	reg [1:0] op;
	wire instr_ready, carry_flag_we, carry_flag, overflow_flag_we, overflow_flag, range_exc;
	wire illegal_insn, rd_we, redirect, flush, ops_idle, custom_valid, custom_done;
	wire [4:0] rd_addr;
	wire [31:0] rd_data, effective_target, custom_word;
	wire [7:0] custom_slot;
	integer n_mismatch, checks, i, k;
	fbx_exec dut (.*);
	fbx_core_model core (.*);
	function [31:0] nx(input [31:0] s);
		nx = s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
	endfunction
	function [31:0] ex(input [1:0] o, input [31:0] x, input [31:0] y, input f);
		case (o)
		2'h0: ex = f ? x : y;
		2'h1: ex = {{24{x[7]}}, x[7:0]};
		default: ex = {24'h0, x[7:0]};
		endcase
	endfunction
	function [31:0] dq(input s, input [31:0] x, input [31:0] y);
		if (s)
			dq = $signed(x) / $signed(y);
		else
			dq = x / y;
	endfunction
	task ck(input ok, input [8*8:1] m);
		begin
			checks = checks + 1;
			if (ok !== 1'b1) begin
				n_mismatch = n_mismatch + 1;
				$display("mismatch at %0t: %0s", $time, m);
			end
		end
	endtask
	task conclude;
		begin
			$display("checks %0d n_mismatch %0d", checks, n_mismatch);
			if (n_mismatch == 0 && checks > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	// holds the word until taken, returns at the falling edge after the take
	task go(input [31:0] w, input [31:0] x, input [31:0] y, input f);
		begin
			instr = w;
			src_a = x;
			src_b = y;
			compare_flag = f;
			instr_pc = instr_pc + 32'h4;
			instr_valid = 1'b1;
			for (k = 0; !instr_ready; k = k + 1) begin
				if (k > 80) begin
					n_mismatch = n_mismatch + 1;
					conclude;
				end
				@(negedge clk);
			end
			@(negedge clk);
		end
	endtask
	// a wait that runs out is a mismatch and ends the run at once
	task await(input sel);
		begin
			for (k = 0; (sel ? flush : rd_we) !== 1'b1 && k < 60; k = k + 1)
				@(negedge clk);
			if (k >= 60) begin
				n_mismatch = n_mismatch + 1;
				conclude;
			end
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		{rst_n, instr_valid, compare_flag, instr, instr_pc, src_a, src_b, lag} = 0;
		n_mismatch = 0;
		checks = 0;
		rnd = 32'h5d;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		for (i = 0; i < 40; i = i + 1) begin
			rnd = nx(rnd);
			a = rnd;
			rnd = nx(rnd);
			b = rnd;
			op = rnd[1:0];
			q = {6'h38, rnd[20:16], 5'h01, op == 2'h0 ? 16'h100e : op == 2'h1 ? 16'h004c : 16'h00cc};
			go(op == 2'h3 ? 32'h14000000 : q, a, b, rnd[5]);
			ck(rd_we === (op != 2'h3) && range_exc === 1'b0 && illegal_insn === 1'b0, "write");
			if (op != 2'h3)
				ck(rd_data === ex(op, a, b, rnd[5]) && rd_addr === rnd[20:16], "result");
		end
		for (i = 0; i < 9; i = i + 1) begin
			rnd = nx(rnd);
			case (i)
			0: {a, b, sg} = {32'h7, 32'h0, 1'b1};
			1: {a, b, sg} = {32'h80000000, 32'hffffffff, 1'b1};
			2: {a, b, sg} = {32'hfffffff9, 32'h2, 1'b1};
			3: {a, b, sg} = {32'hfffffff0, 32'h3, 1'b0};
			4: {a, b, sg} = {32'h5, 32'h0, 1'b0};
			default: {a, b, sg} = {rnd, 24'h0, rnd[7:1], 1'b1, rnd[9]};
			endcase
			go({6'h38, 5'h04, 5'h01, 16'h1309 + {15'h0, !sg}}, a, b, 1'b0);
			ck(illegal_insn === 1'b0 && instr_ready === 1'b0, "divlegal");
			instr_valid = 1'b0;
			await(1'b0);
			t = {31'h0, b == 32'h0 || (sg && a == 32'h80000000 && b == 32'hffffffff)};
			ck(rd_we === 1'b1 && rd_addr === 5'h04 && carry_flag === (b == 32'h0), "dflag");
			ck(overflow_flag === t[0] && range_exc === t[0], "dovf");
			if (!t[0])
				ck(rd_data === dq(sg, a, b), "quot");
		end
		for (i = 0; i < 2; i = i + 1) begin
			rnd = nx(rnd);
			go({6'h03, rnd[25:0]}, 0, 0, i[0]);
			t = instr_pc + {{4{rnd[25]}}, rnd[25:0], 2'h0};
			ck(redirect === 1'b0, "early");
			go({6'h38, 5'h03, 5'h01, 16'h100e}, rnd, 0, i[0]);
			ck(redirect === !i[0] && rd_we === 1'b1, "redir");
			if (!i[0])
				ck(effective_target === t, "target");
		end
		for (i = 0; i < 2; i = i + 1) begin
			lag = i[0] ? 4'h9 : 4'h0;
			go(`FBX_CSYNC_WORD, 0, 0, 1'b0);
			instr_valid = 1'b0;
			await(1'b1);
			ck(flush === 1'b1 && k >= lag, "flush");
			@(negedge clk);
			ck(instr_ready === 1'b1, "resume");
		end
		lag = 4'h3;
		for (i = 0; i < 8; i = i + 1) begin
			rnd = nx(rnd);
			q = {i[2], 3'h7, i[1:0], rnd[25:0]};
			go(q, 0, 0, 1'b0);
			ck(custom_valid === 1'b1 && custom_slot === (8'h01 << i) && custom_word === q, "custom");
		end
		instr_valid = 1'b0;
		repeat (10) @(negedge clk);
		conclude;
	end
endmodule
